// ---- vic_pkg.sv ----
// Package for the vectored interrupt prioritizer.
// Assumes a single 100 MHz clock and a plain strobe register port.
`default_nettype none

package vic_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_CHAN = 32;
  localparam int NUM_SLOTS = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CHAN_IDX_W = 5;

  // ==========================================================================
  // Fixed request channel numbers
  localparam int CH_WATCHDOG = 0;
  localparam int CH_SOFT_ONLY = 1;
  localparam int CH_DBG_RX = 2;
  localparam int CH_DBG_TX = 3;
  localparam int CH_TIMER0 = 4;
  localparam int CH_TIMER1 = 5;
  localparam int CH_SERIAL0 = 6;
  localparam int CH_SERIAL1 = 7;
  localparam int CH_PWM = 8;
  localparam int CH_I2C = 9;
  localparam int CH_SPI0 = 10;
  localparam int CH_SPI1_SSP = 11;
  localparam int CH_PLL = 12;
  localparam int CH_RTC = 13;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h00;
  localparam logic [7:0] OFS_FIQ_STATUS = 8'h04;
  localparam logic [7:0] OFS_RAW_STATUS = 8'h08;
  localparam logic [7:0] OFS_FIQ_SELECT = 8'h0C;
  localparam logic [7:0] OFS_ENABLE = 8'h10;
  localparam logic [7:0] OFS_SOFT_SET = 8'h18;
  localparam logic [7:0] OFS_SOFT_CLR = 8'h1C;
  localparam logic [7:0] OFS_VECT_ADDR = 8'h30;
  localparam logic [7:0] OFS_DEF_ADDR = 8'h34;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h38;
  localparam logic [7:0] OFS_EVT_MASK = 8'h3C;
  localparam logic [7:0] OFS_SLOT_ADDR = 8'h40;
  localparam logic [7:0] OFS_SLOT_CTRL = 8'h80;

  // ==========================================================================
  // Slot control fields and reset values
  localparam int SLOT_EN_BIT = 5;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [3:0] EVT_IRQ_BIT = 4'h0;
  localparam logic [3:0] EVT_FIQ_BIT = 4'h1;

  // Slot setup carried together
  typedef struct packed {
    logic en;
    logic [CHAN_IDX_W-1:0] chan;
  } vic_slot_t;

  // Peripheral flag bundles
  typedef struct packed {
    logic [3:0] match;
    logic [3:0] capture;
  } vic_timer_flags_t;

  typedef struct packed {
    logic rx_line_status_flag;
    logic tx_holding_empty_flag;
    logic rx_data_available_flag;
    logic char_timeout_flag;
    logic modem_status_flag;
  } vic_serial_flags_t;

  typedef struct packed {
    logic spi_transfer_done_flag;
    logic spi_mode_fault_flag;
    logic ssp_tx_raw_flag;
    logic ssp_rx_raw_flag;
    logic ssp_rx_timeout_raw_flag;
    logic ssp_rx_overrun_raw_flag;
  } vic_spi_ssp_flags_t;

endpackage : vic_pkg

`default_nettype wire

// ---- vic_slot_arbiter.sv ----
// Fixed-priority search of the vectored slots.
// Assumes slot requests and addresses come from logic on the same clock.
`default_nettype none

module vic_slot_arbiter
  import vic_pkg::*;
#(
  parameter int SLOTS = NUM_SLOTS
) (
  // Per-slot requests and addresses
  input wire logic [SLOTS-1:0] slot_req_i,
  input wire logic [SLOTS*DATA_W-1:0] slot_addr_i,
  // Winner
  output logic hit_o,
  output logic [DATA_W-1:0] addr_o
);

  // ==========================================================================
  // Search from the highest slot number down; the lowest slot number ranks highest
  always_comb begin
    hit_o = 1'b0;
    addr_o = RST_ZERO;
    for (int s = SLOTS - 1; s >= 0; s--) begin
      if (slot_req_i[s]) begin
        hit_o = 1'b1;
        addr_o = slot_addr_i[s*DATA_W +: DATA_W];
      end
    end
  end

endmodule : vic_slot_arbiter

`default_nettype wire

// ---- vic_irq_prioritizer.sv ----
// Vectored interrupt prioritizer: request gathering, masking, slot
// arbitration, vector address read-out and the core interrupt outputs.
// Assumes peripheral flags are synchronous to clk_i (on-chip logic).
//
// How it works
// - Any channel to any of sixteen slots
// - Vectored slots rank below fast, above plain
// - Unslotted requests rank lowest, non-vectored
// - Vectored and plain requests merge into irq
// - Vector read gives lowest-numbered requesting slot address
// - No slot requesting: default address returned
// - Readable status shows active requests
// - One OR-ed request line per peripheral
// - Channel 0 watchdog, channel 1 software only
// - Timers drive channels 4 and 5
// - Serial ports drive channels 6 and 7
// - PWM match flags drive channel 8
// - SPI1 and SSP share channel 11
// - RTC increment and alarm drive 13
`default_nettype none

module vic_irq_prioritizer
  import vic_pkg::*;
#(
  parameter int SLOTS = NUM_SLOTS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Peripheral flags
  input wire logic watchdog_irq_flag_i,
  input wire logic debug_channel_rx_flag_i,
  input wire logic debug_channel_tx_flag_i,
  input wire vic_timer_flags_t timer0_flags_i,
  input wire vic_timer_flags_t timer1_flags_i,
  input wire vic_serial_flags_t serial0_flags_i,
  input wire vic_serial_flags_t serial1_flags_i,
  input wire logic [6:0] pwm_match_flags_i,
  input wire logic i2c_state_flag_i,
  input wire logic [1:0] spi0_flags_i,
  input wire vic_spi_ssp_flags_t spi1_ssp_flags_i,
  input wire logic pll_lock_flag_i,
  input wire logic rtc_increment_flag_i,
  input wire logic rtc_alarm_flag_i,
  input wire logic [NUM_CHAN-1:14] extra_req_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // Core interrupt outputs
  output logic irq_o,
  output logic fiq_o,
  output logic evt_irq_o
);

  // Elaboration check: slot addressing fits the map
  if (SLOTS < 1 || SLOTS > NUM_SLOTS) begin : g_bad_slots
    $error("SLOTS must be 1 to 16");
  end

  // ==========================================================================
  // Software-written state
  logic [NUM_CHAN-1:0] enable_reg;
  logic [NUM_CHAN-1:0] fiq_sel_reg;
  logic [NUM_CHAN-1:0] soft_reg;
  logic [DATA_W-1:0] def_addr_reg;
  logic [1:0] evt_stat_reg;
  logic [1:0] evt_mask_reg;
  vic_slot_t slot_reg [SLOTS];
  logic [DATA_W-1:0] slot_addr_reg [SLOTS];

  // ==========================================================================
  // Request gathering: one OR-ed line per peripheral
  // Each peripheral offers a bundle of flags; only their OR reaches us.
  // The flags are levels from logic on this clock, so no synchroniser.
  // Serial port 0 has no modem flag, so its lowest bundle bit is skipped.
  // Channel 1 has no hardware source: only the software set reaches it.
  // Channels above the fixed map come straight from extra_req_i.
  logic [NUM_CHAN-1:0] hw_req;
  always_comb begin
    hw_req = '0;
    hw_req[CH_WATCHDOG] = watchdog_irq_flag_i;
    hw_req[CH_SOFT_ONLY] = 1'b0;
    hw_req[CH_DBG_RX] = debug_channel_rx_flag_i;
    hw_req[CH_DBG_TX] = debug_channel_tx_flag_i;
    hw_req[CH_TIMER0] = |timer0_flags_i;
    hw_req[CH_TIMER1] = |timer1_flags_i;
    hw_req[CH_SERIAL0] = |serial0_flags_i[4:1];
    hw_req[CH_SERIAL1] = |serial1_flags_i;
    hw_req[CH_PWM] = |pwm_match_flags_i;
    hw_req[CH_I2C] = i2c_state_flag_i;
    hw_req[CH_SPI0] = |spi0_flags_i;
    hw_req[CH_SPI1_SSP] = |spi1_ssp_flags_i;
    hw_req[CH_PLL] = pll_lock_flag_i;
    hw_req[CH_RTC] = rtc_increment_flag_i | rtc_alarm_flag_i;
    hw_req[NUM_CHAN-1:14] = extra_req_i;
  end

  // Raw, enabled and split request sets
  // Raw holds hardware and software requests before any enable.
  // Active requests are raw requests whose channel is enabled.
  // A channel steered to the fast path never reaches a vectored slot,
  // which is what puts the fast category above every slot.
  logic [NUM_CHAN-1:0] raw_req;
  logic [NUM_CHAN-1:0] act_req;
  logic [NUM_CHAN-1:0] irq_req;
  logic [NUM_CHAN-1:0] fiq_req;
  assign raw_req = hw_req | soft_reg;
  assign act_req = raw_req & enable_reg;
  assign fiq_req = act_req & fiq_sel_reg;
  assign irq_req = act_req & ~fiq_sel_reg;

  // ==========================================================================
  // Slot requests: a slot fires when its channel is an active irq request
  // Two slots may name one channel; the lower slot then wins.
  // A disabled slot is skipped, so its channel falls to the plain group.
  // The address table is flattened for the arbiter below.
  logic [SLOTS-1:0] slot_req;
  logic [SLOTS*DATA_W-1:0] slot_addr_flat;
  always_comb begin
    for (int s = 0; s < SLOTS; s++) begin
      slot_req[s] = slot_reg[s].en & irq_req[slot_reg[s].chan];
      slot_addr_flat[s*DATA_W +: DATA_W] = slot_addr_reg[s];
    end
  end

  logic vect_hit;
  logic [DATA_W-1:0] vect_addr;
  vic_slot_arbiter #(
    .SLOTS(SLOTS)
  ) u_arb (
    .slot_req_i(slot_req),
    .slot_addr_i(slot_addr_flat),
    .hit_o(vect_hit),
    .addr_o(vect_addr)
  );

  // ==========================================================================
  // Decode helper
  // Exact byte match on the register offset; low address bits count,
  // so a misaligned access hits nothing and is ignored.
  // Slot areas decode on the top two bits and index by word.
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic slot_area;
  logic ctrl_area;
  logic [3:0] slot_idx;
  assign slot_area = (addr_i[7:6] == OFS_SLOT_ADDR[7:6]);
  assign ctrl_area = (addr_i[7:6] == OFS_SLOT_CTRL[7:6]);
  assign slot_idx = addr_i[5:2];

  // ==========================================================================
  // Channel enable, fast select and software request registers
  // Set and clear of the software requests live at separate offsets,
  // so a read-modify-write in software cannot lose a hardware request.
  // Software requests stand until cleared by software.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_reg <= RST_ZERO;
      fiq_sel_reg <= RST_ZERO;
      soft_reg <= RST_ZERO;
    end else if (wr_i) begin
      if (hit(addr_i, OFS_ENABLE)) enable_reg <= wdata_i;
      if (hit(addr_i, OFS_FIQ_SELECT)) fiq_sel_reg <= wdata_i;
      if (hit(addr_i, OFS_SOFT_SET)) soft_reg <= soft_reg | wdata_i;
      if (hit(addr_i, OFS_SOFT_CLR)) soft_reg <= soft_reg & ~wdata_i;
    end
  end

  // Default address for non-vectored requests
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      def_addr_reg <= RST_ZERO;
    end else if (wr_i && hit(addr_i, OFS_DEF_ADDR)) begin
      def_addr_reg <= wdata_i;
    end
  end

  // Slot table: channel, enable and routine address per slot
  // Writes to slot numbers beyond SLOTS are dropped.
  // Address and control of one slot are separate words.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int s = 0; s < SLOTS; s++) begin
        slot_reg[s] <= '0;
        slot_addr_reg[s] <= RST_ZERO;
      end
    end else if (wr_i && 32'(slot_idx) < SLOTS) begin
      if (slot_area) begin
        slot_addr_reg[slot_idx] <= wdata_i;
      end
      if (ctrl_area) begin
        slot_reg[slot_idx].en <= wdata_i[SLOT_EN_BIT];
        slot_reg[slot_idx].chan <= wdata_i[CHAN_IDX_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Core outputs: fast path separate, vectored and plain merged
  // Both are registered, so they follow the requests one cycle late.
  // Priority inside the irq group is left to the vector read.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      fiq_o <= 1'b0;
    end else begin
      fiq_o <= |fiq_req;
      irq_o <= |irq_req;
    end
  end

  // ==========================================================================
  // Event status: rising edges of irq and fiq, write one to clear
  // The edge trackers reset low, matching the idle request level,
  // so no false event follows reset.
  // Bit 0 records an irq rise, bit 1 a fast rise.
  logic irq_any_q;
  logic fiq_any_q;
  logic [1:0] evt_set;
  assign evt_set = {(|fiq_req) & ~fiq_any_q, (|irq_req) & ~irq_any_q};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_any_q <= 1'b0;
      fiq_any_q <= 1'b0;
      evt_stat_reg <= 2'h0;
      evt_mask_reg <= 2'h0;
    end else begin
      irq_any_q <= |irq_req;
      fiq_any_q <= |fiq_req;
      // Set beats a same-cycle clear
      if (wr_i && hit(addr_i, OFS_EVT_STATUS)) begin
        evt_stat_reg <= (evt_stat_reg & ~wdata_i[1:0]) | evt_set;
      end else begin
        evt_stat_reg <= evt_stat_reg | evt_set;
      end
      if (wr_i && hit(addr_i, OFS_EVT_MASK)) evt_mask_reg <= wdata_i[1:0];
    end
  end

  // Level interrupt while an unmasked event bit stands
  // A new event shows here in the same cycle that its status bit sets.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_irq_o <= 1'b0;
    end else begin
      evt_irq_o <= |((evt_stat_reg | evt_set) & evt_mask_reg);
    end
  end

  // ==========================================================================
  // Read mux, data valid the cycle after the strobe
  // Status words are live views, not snapshots.
  // The vector read gives the winning slot, else the default routine.
  // Unmapped offsets read as zero.
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = RST_ZERO;
    if (slot_area && 32'(slot_idx) < SLOTS) begin
      rd_mux = slot_addr_reg[slot_idx];
    end else if (ctrl_area && 32'(slot_idx) < SLOTS) begin
      rd_mux[SLOT_EN_BIT] = slot_reg[slot_idx].en;
      rd_mux[CHAN_IDX_W-1:0] = slot_reg[slot_idx].chan;
    end else begin
      case (addr_i)
        OFS_IRQ_STATUS: rd_mux = irq_req;
        OFS_FIQ_STATUS: rd_mux = fiq_req;
        OFS_RAW_STATUS: rd_mux = raw_req;
        OFS_FIQ_SELECT: rd_mux = fiq_sel_reg;
        OFS_ENABLE: rd_mux = enable_reg;
        OFS_SOFT_SET: rd_mux = soft_reg;
        OFS_VECT_ADDR: rd_mux = vect_hit ? vect_addr : def_addr_reg;
        OFS_DEF_ADDR: rd_mux = def_addr_reg;
        OFS_EVT_STATUS: rd_mux[1:0] = evt_stat_reg;
        OFS_EVT_MASK: rd_mux[1:0] = evt_mask_reg;
        default: rd_mux = RST_ZERO;
      endcase
    end
  end

  // Read data stand one cycle only and are zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= RST_ZERO;
    end else if (rd_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= RST_ZERO;
    end
  end

endmodule : vic_irq_prioritizer

`default_nettype wire

// ---- vic_irq_properties.sv ----
// Port checker for the interrupt prioritizer.
// Assumes it is bound onto vic_irq_prioritizer with one clock.
`default_nettype none
// ======
// Checker
module vic_irq_properties
  import vic_pkg::*;
#(
  parameter int SLOTS = NUM_SLOTS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Flags
  input wire logic watchdog_irq_flag_i,
  input wire logic debug_channel_rx_flag_i,
  input wire logic debug_channel_tx_flag_i,
  input wire vic_timer_flags_t timer0_flags_i,
  input wire vic_timer_flags_t timer1_flags_i,
  input wire vic_serial_flags_t serial0_flags_i,
  input wire vic_serial_flags_t serial1_flags_i,
  input wire logic [6:0] pwm_match_flags_i,
  input wire logic i2c_state_flag_i,
  input wire logic [1:0] spi0_flags_i,
  input wire vic_spi_ssp_flags_t spi1_ssp_flags_i,
  input wire logic pll_lock_flag_i,
  input wire logic rtc_increment_flag_i,
  input wire logic rtc_alarm_flag_i,
  input wire logic [NUM_CHAN-1:14] extra_req_i,
  // Register port and outputs
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic irq_o,
  input wire logic fiq_o,
  input wire logic evt_irq_o
);
  logic [31:0] en_q, fs_q, sf_q, mk_q, hw, raw, pi, pf;
  // Channel lines as the core should see them
  assign hw = {extra_req_i, rtc_increment_flag_i | rtc_alarm_flag_i, pll_lock_flag_i,
    |spi1_ssp_flags_i, |spi0_flags_i, i2c_state_flag_i, |pwm_match_flags_i, |serial1_flags_i,
    |serial0_flags_i[4:1], |timer1_flags_i, |timer0_flags_i, debug_channel_tx_flag_i,
    debug_channel_rx_flag_i, 1'b0, watchdog_irq_flag_i};
  assign raw = hw | sf_q;
  assign pi = raw & en_q & ~fs_q;
  assign pf = raw & en_q & fs_q;
  // Shadow of the steering registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= '0;
      fs_q <= '0;
      sf_q <= '0;
      mk_q <= '0;
    end else if (wr_i) begin
      case (addr_i)
        OFS_ENABLE: en_q <= wdata_i;
        OFS_FIQ_SELECT: fs_q <= wdata_i;
        OFS_SOFT_SET: sf_q <= sf_q | wdata_i;
        OFS_SOFT_CLR: sf_q <= sf_q & ~wdata_i;
        OFS_EVT_MASK: mk_q <= wdata_i;
        default: ;
      endcase
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  irq_set_a: assert property (|pi |=> irq_o) else $error("irq low");
  irq_clear_a: assert property (!(|pi) |=> !irq_o) else $error("irq high");
  fiq_match_a: assert property (|pf |=> fiq_o) else $error("fiq");
  fiq_clear_a: assert property (!(|pf) |=> !fiq_o) else $error("fiq high");
  raw_read_a: assert property (rd_i && addr_i == OFS_RAW_STATUS |=>
    rdata_o == $past(raw)) else $error("raw status");
  irq_read_a: assert property (rd_i && addr_i == OFS_IRQ_STATUS |=>
    rdata_o == $past(pi)) else $error("irq status");
  rdata_idle_a: assert property (!rd_i |=> rdata_o == '0) else $error("rdata");
  unmapped_rd_a: assert property (rd_i && addr_i[7:6] == 2'b11 |=>
    rdata_o == '0) else $error("unmapped");
  evt_rise_a: assert property ($rose(irq_o) && mk_q[0] |-> ##[1:3] evt_irq_o)
    else $error("event");
  evt_mask_a: assert property (mk_q[1:0] == 2'b00 |=> !evt_irq_o) else $error("mask");
  cover property (rd_i && addr_i == OFS_VECT_ADDR && |pi);
  cover property (fiq_o);
  cover property (evt_irq_o);
endmodule : vic_irq_properties

bind vic_irq_prioritizer vic_irq_properties #(.SLOTS(SLOTS)) vic_irq_properties_inst (
  .clk_i(clk_i), .rst_i(rst_i), .watchdog_irq_flag_i(watchdog_irq_flag_i),
  .debug_channel_rx_flag_i(debug_channel_rx_flag_i),
  .debug_channel_tx_flag_i(debug_channel_tx_flag_i), .timer0_flags_i(timer0_flags_i),
  .timer1_flags_i(timer1_flags_i), .serial0_flags_i(serial0_flags_i),
  .serial1_flags_i(serial1_flags_i), .pwm_match_flags_i(pwm_match_flags_i),
  .i2c_state_flag_i(i2c_state_flag_i), .spi0_flags_i(spi0_flags_i),
  .spi1_ssp_flags_i(spi1_ssp_flags_i), .pll_lock_flag_i(pll_lock_flag_i),
  .rtc_increment_flag_i(rtc_increment_flag_i), .rtc_alarm_flag_i(rtc_alarm_flag_i),
  .extra_req_i(extra_req_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .irq_o(irq_o), .fiq_o(fiq_o), .evt_irq_o(evt_irq_o));
`default_nettype wire

// ---- vic_periph_model.sv ----
// Peripheral side: raises one flag of each requested peripheral.
// Assumes req_i names channels and pick_i chooses the flag.
`default_nettype none
// ======
// Flag model
module vic_periph_model
  import vic_pkg::*;
(
  // Clock and commands
  input wire logic clk_i,
  input wire logic [31:0] req_i,
  input wire logic [2:0] pick_i,
  // Flag lines
  output logic wd_o,
  output logic drx_o,
  output logic dtx_o,
  output vic_timer_flags_t t0_o,
  output vic_timer_flags_t t1_o,
  output vic_serial_flags_t s0_o,
  output vic_serial_flags_t s1_o,
  output logic [6:0] pwm_o,
  output logic i2c_o,
  output logic [1:0] sp0_o,
  output vic_spi_ssp_flags_t sp1_o,
  output logic pll_o,
  output logic rinc_o,
  output logic ralm_o,
  output logic [31:14] ext_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Any single internal flag must light its peripheral's line
  always_ff @(posedge clk_i) begin
    wd_o <= req_i[0];
    drx_o <= req_i[2];
    dtx_o <= req_i[3];
    t0_o <= req_i[4] ? 8'h01 << pick_i : 8'h00;
    t1_o <= req_i[5] ? 8'h01 << pick_i : 8'h00;
    s0_o <= req_i[6] ? 5'h02 << pick_i[1:0] : 5'h00; // No modem flag on port 0
    s1_o <= req_i[7] ? 5'h01 << (pick_i % 3'h5) : 5'h00;
    pwm_o <= req_i[8] ? 7'h01 << (pick_i % 3'h7) : 7'h00;
    i2c_o <= req_i[9];
    sp0_o <= req_i[10] ? 2'h1 << pick_i[0] : 2'h0;
    sp1_o <= req_i[11] ? 6'h01 << (pick_i % 3'h6) : 6'h00;
    pll_o <= req_i[12];
    rinc_o <= req_i[13] & ~pick_i[0];
    ralm_o <= req_i[13] & pick_i[0];
    ext_o <= req_i[31:14];
  end
endmodule : vic_periph_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the interrupt prioritizer.
// Assumes the peripheral model drives every flag input.
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
// ======
// Bench
module testbench
  import vic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, req = 32'h0, xd, q[$], sa[16];
  logic [5:0] sc[16];
  logic [2:0] pick = 3'h0;
  logic irq, fiq, evt, wd, drx, dtx, i2c, pll, rinc, ralm;
  vic_timer_flags_t t0, t1;
  vic_serial_flags_t s0, s1;
  logic [6:0] pwm;
  logic [1:0] sp0;
  vic_spi_ssp_flags_t sp1;
  logic [31:14] ext;
  int n_errors = 0, n_tests = 0, cyc = 0, seed = 32'h0ECC;
  vic_irq_prioritizer vic_irq_prioritizer_inst (.clk_i(clk_i), .rst_i(rst_i),
    .watchdog_irq_flag_i(wd), .debug_channel_rx_flag_i(drx), .debug_channel_tx_flag_i(dtx),
    .timer0_flags_i(t0), .timer1_flags_i(t1), .serial0_flags_i(s0), .serial1_flags_i(s1),
    .pwm_match_flags_i(pwm), .i2c_state_flag_i(i2c), .spi0_flags_i(sp0),
    .spi1_ssp_flags_i(sp1), .pll_lock_flag_i(pll), .rtc_increment_flag_i(rinc),
    .rtc_alarm_flag_i(ralm), .extra_req_i(ext), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .fiq_o(fiq), .evt_irq_o(evt));
  vic_periph_model vic_periph_model_inst (.clk_i(clk_i), .req_i(req), .pick_i(pick),
    .wd_o(wd), .drx_o(drx), .dtx_o(dtx), .t0_o(t0), .t1_o(t1), .s0_o(s0), .s1_o(s1),
    .pwm_o(pwm), .i2c_o(i2c), .sp0_o(sp0), .sp1_o(sp1), .pll_o(pll), .rinc_o(rinc),
    .ralm_o(ralm), .ext_o(ext));
  initial forever #5 clk_i = ~clk_i;
  task automatic give_verdict();
    $display("errors %0d, checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  // Read data against the oldest note, plus the hang limit
  always @(posedge clk_i) begin
    if (rd_d) begin
      xd = q.pop_front();
      `CHK(rdata, xd)
    end
    rd_d <= rd;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk_i);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    q.push_back(e);
    @(posedge clk_i);
  endtask : rreg
  task automatic see(input logic i, input logic f, input logic v);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK(irq, i)
    `CHK(fiq, f)
    `CHK(evt, v)
    @(posedge clk_i);
  endtask : see
  // Lowest enabled slot whose channel is pending, else the default
  function automatic logic [31:0] vexp(input logic [31:0] p, input logic [31:0] d);
    for (int n = 15; n >= 0; n--) if (sc[n][5] && p[sc[n][4:0]]) d = sa[n];
    return d;
  endfunction : vexp
  initial begin
    logic [31:0] en, fs, sm, df, p, e;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values and an unmapped place
    wreg(8'hC0, 32'hFFFF_FFFF);
    foreach (sa[i]) if (i < 7) rreg(8'(i * 4) + 8'h0C * 8'(i > 3), RST_ZERO);
    rreg(8'hC0, 32'h0);
    // Each peripheral reaches its own channel
    wreg(OFS_ENABLE, 32'hFFFF_FFFF);
    for (int c = 0; c < 32; c++) begin
      req <= 32'h1 << c;
      pick <= 3'($random(seed));
      // Outputs still show the previous channel one edge after the new request
      see(c != 0 && c != 2, 1'b0, 1'b0);
      e = (c == 1) ? 32'h0 : 32'h1 << c;
      rreg(OFS_RAW_STATUS, e);
      see(|e, 1'b0, 1'b0);
    end
    req <= 32'h0;
    // Slots with random addresses and channels
    df = $random(seed);
    wreg(OFS_DEF_ADDR, df);
    for (int n = 0; n < 16; n++) begin
      sa[n] = $random(seed);
      sc[n] = 6'($random(seed));
      wreg(OFS_SLOT_ADDR + 8'(4 * n), sa[n]);
      wreg(OFS_SLOT_CTRL + 8'(4 * n), {26'h0, sc[n]});
    end
    for (int k = 0; k < 60; k++) begin
      en = $random(seed);
      fs = $random(seed) & $random(seed);
      sm = $random(seed);
      if (k % 4 == 0) sm = sm & fs;
      p = sm & en & ~fs;
      wreg(OFS_ENABLE, en);
      wreg(OFS_FIQ_SELECT, fs);
      wreg(OFS_SOFT_CLR, 32'hFFFF_FFFF);
      wreg(OFS_SOFT_SET, sm);
      rreg(OFS_VECT_ADDR, vexp(p, df));
      rreg(OFS_FIQ_STATUS, sm & en & fs);
      see(|p, |(sm & en & fs), 1'b0);
    end
    // Sticky events, mask and clear
    wreg(OFS_SOFT_CLR, 32'hFFFF_FFFF);
    wreg(OFS_FIQ_SELECT, 32'h0);
    wreg(OFS_ENABLE, 32'h10);
    wreg(OFS_EVT_MASK, 32'h3);
    wreg(OFS_EVT_STATUS, 32'h3);
    req <= 32'h10;
    see(1'b0, 1'b0, 1'b0);
    see(1'b1, 1'b0, 1'b1);
    wreg(OFS_FIQ_SELECT, 32'h10);
    see(1'b0, 1'b1, 1'b1);
    rreg(OFS_EVT_STATUS, 32'h3);
    wreg(OFS_EVT_MASK, 32'h0);
    see(1'b0, 1'b1, 1'b0);
    wreg(OFS_EVT_MASK, 32'h3);
    wreg(OFS_EVT_STATUS, 32'h3);
    see(1'b0, 1'b1, 1'b0);
    rreg(OFS_EVT_STATUS, 32'h0);
    see(1'b0, 1'b1, 1'b0);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
